// ### logic/igds_map.svh
// Purpose: constants for the isolated gate drive sequencer
// Assumes: 100 MHz sequencer clock (10 ns)
// Notes: times in ns, long-off and predischarge cycle counts derived from them
`ifndef IGDS_MAP_SVH
`define IGDS_MAP_SVH
`define IGDS_CLK_PERIOD_NS 10
`define IGDS_LONG_OFF_NS 32000
`define IGDS_LONG_OFF_CYC (`IGDS_LONG_OFF_NS / `IGDS_CLK_PERIOD_NS)
`define IGDS_PREDIS_NS 20
`define IGDS_PREDIS_CYC ((`IGDS_PREDIS_NS + `IGDS_CLK_PERIOD_NS - 1) / `IGDS_CLK_PERIOD_NS)
`define IGDS_FAST_GAP_CYC 16
`define IGDS_SLOW_GAP_CYC 256
`define IGDS_WDOG_SLOW_CYC 64
`define IGDS_WDOG_LOST_CYC 1024
`define IGDS_NEG_OFF_DEF 100
`endif

// ### logic/igds_pkg.sv
// Purpose: types for the isolated gate drive sequencer
// Assumes: nothing
// Notes: drive states of the output side
package igds_pkg;
	typedef enum logic [2:0] {
		IGDS_DEEP_OFF = 3'b000,
		IGDS_PREDIS = 3'b001,
		IGDS_ON = 3'b010,
		IGDS_NEG_OFF = 3'b011,
		IGDS_ZERO_OFF = 3'b100
	} igds_state_t;
endpackage

// ### logic/igds_sequencer.sv
// Purpose: pwm to four-switch sequencer across an isolation link
// Assumes: lockout flags and pwm are asynchronous pins
// Notes: link modelled as a pulse toggle inside one clock
`timescale 1ns/100ps
`default_nettype none
`include "igds_map.svh"

// Contract
// - outputs move only with both supplies valid
// - separate gate and source output valid flags
// - input flag hysteresis done by analog comparator
// - input supply loss forces deep-off state
// - output lockout independent of input lockout
// - pulse train link with receiver watchdog
// - slower pulse rate after 32 us off
// - slow rate opens discharge, closes deep-off
// - negative-off duration is a configurable count
// - predischarge before turn-on from deep-off
// - zero level after negative-off until next event
// - long-off uses full negative supply
module igds_sequencer
	import igds_pkg::*;
#(
	parameter int unsigned NEG_OFF_W = 16,
	parameter int unsigned LONG_OFF_CYC = `IGDS_LONG_OFF_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic pwm_i,
	input wire logic input_lockout_flag_i,
	input wire logic gate_output_lockout_flag_i,
	input wire logic source_output_lockout_flag_i,
	input wire logic [NEG_OFF_W-1:0] negative_off_duration_i,
	output logic gate_pull_up_o,
	output logic gate_pull_down_o,
	output logic discharge_switch_o,
	output logic deep_off_switch_o,
	output logic long_off_o
);

	////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] pwm_s_q, pwm_s_d;
	logic [1:0] vin_s_q, vin_s_d;
	logic [1:0] vg_s_q, vg_s_d;
	logic [1:0] vs_s_q, vs_s_d;

	always_comb begin
		pwm_s_d = {pwm_s_q[0], pwm_i};
		vin_s_d = {vin_s_q[0], input_lockout_flag_i};
		vg_s_d = {vg_s_q[0], gate_output_lockout_flag_i};
		vs_s_d = {vs_s_q[0], source_output_lockout_flag_i};
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_s_q <= 2'h0;
			vin_s_q <= 2'h0;
			vg_s_q <= 2'h0;
			vs_s_q <= 2'h0;
		end else begin
			pwm_s_q <= pwm_s_d;
			vin_s_q <= vin_s_d;
			vg_s_q <= vg_s_d;
			vs_s_q <= vs_s_d;
		end
	end

	logic pwm_s, in_ok, out_ok;
	assign pwm_s = pwm_s_q[1];
	assign in_ok = vin_s_q[1];
	assign out_ok = vg_s_q[1] & vs_s_q[1];

	////////////////////////////////////////////////////////////
	// transmitter: pulse train, rate drops after long off
	logic [15:0] gap_q, gap_d;
	logic [15:0] toff_q, toff_d;
	logic tx_lvl_q, tx_lvl_d;
	logic link_q, link_d;
	logic tx_slow;

	always_comb begin
		tx_slow = toff_q >= 16'(LONG_OFF_CYC);
		toff_d = toff_q;
		if (pwm_s | ~in_ok) begin
			toff_d = 16'h0;
		end else if (!tx_slow) begin
			toff_d = toff_q + 16'h1;
		end
		gap_d = gap_q + 16'h1;
		link_d = 1'b0;
		tx_lvl_d = tx_lvl_q;
		// level change is sent at once, then repeated
		if (in_ok && (pwm_s != tx_lvl_q || gap_q >= (tx_slow ? 16'(`IGDS_SLOW_GAP_CYC) :
				16'(`IGDS_FAST_GAP_CYC)))) begin
			link_d = 1'b1;
			tx_lvl_d = pwm_s;
			gap_d = 16'h0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			gap_q <= 16'h0;
			toff_q <= 16'h0;
			tx_lvl_q <= 1'b0;
			link_q <= 1'b0;
		end else begin
			gap_q <= gap_d;
			toff_q <= toff_d;
			tx_lvl_q <= tx_lvl_d;
			link_q <= link_d;
		end
	end

	////////////////////////////////////////////////////////////
	// receiver: latch command, watchdog on pulse spacing
	logic rx_cmd_q, rx_cmd_d;
	logic [15:0] wd_q, wd_d;
	logic rx_long_q, rx_long_d;

	always_comb begin
		rx_cmd_d = rx_cmd_q;
		wd_d = wd_q;
		rx_long_d = rx_long_q;
		if (link_q) begin
			rx_cmd_d = tx_lvl_q;
			wd_d = 16'h0;
			if (tx_lvl_q) begin
				rx_long_d = 1'b0;
			end
		end else if (wd_q != 16'hffff) begin
			wd_d = wd_q + 16'h1;
		end
		// an arriving on pulse must win, else a short first pulse skips negative-off
		if (wd_q >= 16'(`IGDS_WDOG_SLOW_CYC) && !rx_cmd_d) begin
			rx_long_d = 1'b1;
		end
		// lost link or input supply: fall back to off
		if (wd_q >= 16'(`IGDS_WDOG_LOST_CYC) || !in_ok) begin
			rx_cmd_d = 1'b0;
			rx_long_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rx_cmd_q <= 1'b0;
			wd_q <= 16'h0;
			rx_long_q <= 1'b1;
		end else begin
			rx_cmd_q <= rx_cmd_d;
			wd_q <= wd_d;
			rx_long_q <= rx_long_d;
		end
	end

	////////////////////////////////////////////////////////////
	// drive state machine
	igds_state_t st_q, st_d;
	logic [NEG_OFF_W-1:0] tmr_q, tmr_d;
	logic gpu_d, gpd_d, dis_d, deep_d;
	logic gpu_q, gpd_q, dis_q, deep_q, long_q;

	always_comb begin
		st_d = st_q;
		tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
		if (!out_ok) begin
			st_d = st_q; // hold while output side unpowered
		end else if (rx_long_q && !rx_cmd_q) begin
			st_d = IGDS_DEEP_OFF;
		end else begin
			case (st_q)
				IGDS_DEEP_OFF: begin
					if (rx_cmd_q) begin
						st_d = IGDS_PREDIS;
						tmr_d = NEG_OFF_W'(`IGDS_PREDIS_CYC);
					end
				end
				IGDS_PREDIS: begin
					if (tmr_q <= NEG_OFF_W'(1)) begin
						st_d = rx_cmd_q ? IGDS_ON : IGDS_NEG_OFF;
						tmr_d = negative_off_duration_i;
					end
				end
				IGDS_ON: begin
					if (!rx_cmd_q) begin
						st_d = IGDS_NEG_OFF;
						tmr_d = negative_off_duration_i;
					end
				end
				IGDS_NEG_OFF: begin
					if (rx_cmd_q) begin
						st_d = IGDS_ON;
					end else if (tmr_q <= NEG_OFF_W'(1)) begin
						st_d = IGDS_ZERO_OFF;
					end
				end
				IGDS_ZERO_OFF: begin
					if (rx_cmd_q) begin
						st_d = IGDS_ON;
					end
				end
				default: begin
					st_d = IGDS_DEEP_OFF;
				end
			endcase
		end
		// gate leg: pull_up/pull_down, source leg: discharge/deep_off
		gpu_d = 1'b0;
		gpd_d = 1'b1;
		dis_d = 1'b0;
		deep_d = 1'b1;
		case (st_d)
			IGDS_ON: begin
				gpu_d = 1'b1;
				gpd_d = 1'b0;
				dis_d = 1'b1;
				deep_d = 1'b0;
			end
			IGDS_PREDIS, IGDS_ZERO_OFF: begin
				dis_d = 1'b1;
				deep_d = 1'b0;
			end
			IGDS_NEG_OFF: begin
				dis_d = 1'b1;
				deep_d = 1'b0;
			end
			default: begin
			end
		endcase
		if (!out_ok) begin
			gpu_d = gpu_q;
			gpd_d = gpd_q;
			dis_d = dis_q;
			deep_d = deep_q;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= IGDS_DEEP_OFF;
			tmr_q <= '0;
			gpu_q <= 1'b0;
			gpd_q <= 1'b1;
			dis_q <= 1'b0;
			deep_q <= 1'b1;
			long_q <= 1'b1;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			gpu_q <= gpu_d & ~gpd_d;
			gpd_q <= gpd_d;
			dis_q <= dis_d & ~deep_d;
			deep_q <= deep_d;
			long_q <= (st_d == IGDS_DEEP_OFF);
		end
	end

	assign gate_pull_up_o = gpu_q;
	assign gate_pull_down_o = gpd_q;
	assign discharge_switch_o = dis_q;
	assign deep_off_switch_o = deep_q;
	assign long_off_o = long_q;

endmodule
`default_nettype wire

// ### tb/igds_chk.sv
// Purpose: gate drive sequencer checker
// Assumes: bound to the top module
// Notes: long-off bound via parameter
`timescale 1ns/100ps
`default_nettype none
module igds_chk #(parameter int unsigned LONG_OFF_CYC = 3200) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic pwm_i,
	input wire logic input_lockout_flag_i,
	input wire logic gate_output_lockout_flag_i,
	input wire logic source_output_lockout_flag_i,
	input wire logic gate_pull_up_o,
	input wire logic gate_pull_down_o,
	input wire logic discharge_switch_o,
	input wire logic deep_off_switch_o,
	input wire logic long_off_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic [15:0] off_q;
	wire logic vo = gate_output_lockout_flag_i && source_output_lockout_flag_i;
	// off time, restarted by every on command; saturates
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) off_q <= 16'h0000;
		else if (pwm_i || !input_lockout_flag_i) off_q <= 16'h0000;
		else if (off_q != 16'hffff) off_q <= off_q + 16'h0001;
	end
	sequence predis_s;
		discharge_switch_o && !gate_pull_up_o && !deep_off_switch_o;
	endsequence
	sequence on_s;
		gate_pull_up_o && !gate_pull_down_o;
	endsequence
	////////////////////////////////////////////////////////////////
	gate_leg_a: assert property (!(gate_pull_up_o && gate_pull_down_o)) else $error("gate leg shorted");
	src_leg_a: assert property (!(discharge_switch_o && deep_off_switch_o)) else $error("source leg shorted");
	deep_lvl_a: assert property (long_off_o |-> deep_off_switch_o && gate_pull_down_o) else $error("deep level");
	predis_a: assert property ($fell(long_off_o) |-> predis_s [*2] ##1 on_s) else $error("no predischarge");
	freeze_a: assert property ((!vo) [*4] |=> $stable({gate_pull_up_o, gate_pull_down_o, discharge_switch_o,
		deep_off_switch_o})) else $error("outputs moved in lockout");
	off_resp_a: assert property ((!pwm_i && vo) [*8] |-> !gate_pull_up_o && gate_pull_down_o) else $error("not off");
	in_lost_a: assert property ($fell(input_lockout_flag_i) |-> ##[1:600] long_off_o) else $error("no fallback");
	long_off_a: assert property (off_q >= LONG_OFF_CYC + 150 |-> long_off_o) else $error("long off late");
endmodule
bind igds_sequencer igds_chk #(.LONG_OFF_CYC(LONG_OFF_CYC)) chk (.clk_sys_i, .rst_i, .pwm_i, .input_lockout_flag_i,
	.gate_output_lockout_flag_i, .source_output_lockout_flag_i, .gate_pull_up_o, .gate_pull_down_o,
	.discharge_switch_o, .deep_off_switch_o, .long_off_o);
`default_nettype wire

// ### tb/igds_pwm_ctl.sv
// Purpose: pwm controller model on the input side
// Assumes: square wave while run_i is high
// Notes: first edge right after run_i rises
`timescale 1ns/100ps
`default_nettype none
module igds_pwm_ctl (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [15:0] half_i,
	output logic pwm_o
);
	logic [15:0] cnt_q;
	////////////////////////////////////////////////////////////////
	// half_i must not shrink below cnt_q while running
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 16'h0000;
			pwm_o <= 1'b0;
		end else if (!run_i) begin
			cnt_q <= 16'h0000;
			pwm_o <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == half_i) ? 16'h0000 : cnt_q + 16'h0001;
			if (cnt_q == 16'h0000) pwm_o <= ~pwm_o;
		end
	end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench for the gate drive sequencer
// Assumes: 100 MHz clock, shortened long-off count
// Notes: pwm comes from the partner model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int unsigned LOFF = 100;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic run = 1'b0;
	logic [15:0] half = 16'h012c;
	logic [2:0] flg = 3'h7;
	logic pwm, up, dn, dis, deep, lo;
	logic [3:0] snap;
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	int i;
	int k;
	igds_pwm_ctl ctl (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run), .half_i(half), .pwm_o(pwm));
	igds_sequencer #(.LONG_OFF_CYC(LOFF)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pwm_i(pwm),
		.input_lockout_flag_i(flg[0]), .gate_output_lockout_flag_i(flg[1]), .source_output_lockout_flag_i(flg[2]),
		.negative_off_duration_i(16'h0008), .gate_pull_up_o(up), .gate_pull_down_o(dn),
		.discharge_switch_o(dis), .deep_off_switch_o(deep), .long_off_o(lo));
	initial forever #5 clk_sys_i = ~clk_sys_i;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic got, input logic exp, input string msg);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	task automatic tick();
		@(posedge clk_sys_i);
		#1;
	endtask
	task automatic t_on();
		@(posedge clk_sys_i);
		run <= 1'b1;
		tick();
		for (i = 0; i < 20 && dis !== 1'b1; i++) tick();
		chk(up, 1'b0, "on too soon");
		tick();
		tick();
		chk(up, 1'b1, "not on");
	endtask
	task automatic t_long();
		for (i = 0; i < 400 && pwm !== 1'b0; i++) tick();
		repeat (20) tick();
		chk(dn, 1'b1, "zero level");
		chk(lo, 1'b0, "long off early");
		for (i = 20; i < 600 && lo !== 1'b1; i++) tick();
		chk(i >= LOFF, 1'b1, "long off short");
		chk(dis, 1'b0, "discharge");
		chk(deep, 1'b1, "deep off");
	endtask
	task automatic t_restart();
		@(posedge clk_sys_i);
		run <= 1'b0;
		@(posedge clk_sys_i);
		half <= 16'h003c;
		run <= 1'b1;
		repeat (20) tick();
		k = 0;
		for (i = 0; i < 400; i++) begin
			tick();
			if (lo !== 1'b0) k++;
		end
		chk(k == 0, 1'b1, "long off on short gaps");
	endtask
	task automatic t_freeze();
		for (k = 1; k < 3; k++) begin
			@(posedge clk_sys_i);
			flg[k] <= 1'b0;
			repeat (4) tick();
			snap = {up, dn, dis, deep};
			for (i = 0; i < 150; i++) begin
				tick();
				chk({up, dn, dis, deep} === snap, 1'b1, "moved");
			end
			@(posedge clk_sys_i);
			flg[k] <= 1'b1;
			repeat (20) tick();
		end
	endtask
	task automatic t_lost();
		@(posedge clk_sys_i);
		flg[0] <= 1'b0;
		tick();
		for (i = 0; i < 600 && lo !== 1'b1; i++) tick();
		chk(lo, 1'b1, "no fallback");
		chk(dn, 1'b1, "gate not low");
		chk(deep, 1'b1, "source not high");
		@(posedge clk_sys_i);
		run <= 1'b0;
		repeat (10) tick();
		@(posedge clk_sys_i);
		flg[0] <= 1'b1;
	endtask
	task automatic print_verdict();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		tick();
		chk(up, 1'b0, "reset up");
		chk(deep, 1'b1, "reset deep");
		t_on();
		t_long();
		t_restart();
		t_freeze();
		t_lost();
		print_verdict();
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 10000) begin
			fails++;
			print_verdict();
		end
	end
endmodule
`default_nettype wire
